/* File: src/pmcal_cal_if.sv */
`timescale 1ns/1ns
interface pmcal_cal_if;
	logic [pmcal_pkg::WORD_W-1:0] addr;
	logic [pmcal_pkg::WORD_W-1:0] data;
	logic hit;

	modport reader (
		output addr,
		input data,
		input hit
	);

	modport rom (
		input addr,
		output data,
		output hit
	);
endinterface : pmcal_cal_if

/* File: src/pmcal_cal_rom.sv */
`timescale 1ns/1ns
module pmcal_cal_rom #(
	parameter logic [13:0] TEMP_VAL = pmcal_pkg::CAL_ERASED,
	parameter logic [13:0] OSC_VAL = pmcal_pkg::CAL_ERASED,
	parameter logic [13:0] SENSE_VAL = pmcal_pkg::CAL_ERASED,
	parameter logic [13:0] HALF_VAL = pmcal_pkg::CAL_ERASED,
	parameter logic [13:0] ADC_VAL = pmcal_pkg::CAL_ERASED,
	parameter logic [13:0] BUF_VAL = pmcal_pkg::CAL_ERASED,
	parameter logic [13:0] GAIN_VAL = pmcal_pkg::CAL_ERASED
) (
	pmcal_cal_if.rom cal
);

	// keeps the low w bits, unused upper bits read as zero
	function automatic logic [13:0] pmcal_field(input logic [13:0] v,
		input int w);
		logic [13:0] m;
		m = 14'h3FFF >> (14 - w);
		return v & m;
	endfunction : pmcal_field

	// ----------------------------------------------------------------
	// read-only lookup
	// ----------------------------------------------------------------
	always_comb begin
		cal.hit = (cal.addr >= pmcal_pkg::CAL_BASE) &&
			(cal.addr <= pmcal_pkg::CAL_TOP);
		case (cal.addr)
			pmcal_pkg::TEMPERATURE_READING_WORD: cal.data =
				pmcal_field(TEMP_VAL, pmcal_pkg::TEMP_AT_30C_COUNT_W);
			pmcal_pkg::OSCILLATOR_TRIM_WORD: cal.data =
				pmcal_field(OSC_VAL, pmcal_pkg::OSC_TRIM_BITS_W);
			pmcal_pkg::SENSE_AMP_OFFSET_WORD: cal.data =
				pmcal_field(SENSE_VAL, pmcal_pkg::SENSE_OFFSET_BITS_W);
			pmcal_pkg::HALF_SUPPLY_READING_WORD: cal.data =
				pmcal_field(HALF_VAL, pmcal_pkg::HALF_SUPPLY_COUNT_W);
			pmcal_pkg::ADC_SCALE_WORD: cal.data =
				pmcal_field(ADC_VAL, pmcal_pkg::ADC_SCALE_BITS_W);
			pmcal_pkg::TEST_BUFFER_OFFSET_WORD: cal.data =
				pmcal_field(BUF_VAL, pmcal_pkg::TEST_BUFFER_OFFSET_BITS_W);
			pmcal_pkg::SENSE_GAIN_ERROR_WORD: cal.data =
				pmcal_field(GAIN_VAL, pmcal_pkg::SENSE_GAIN_ERROR_BITS_W);
			default: cal.data = pmcal_pkg::WORD_ZERO;
		endcase
	end

endmodule : pmcal_cal_rom

/* File: src/pmcal_core.sv */
`timescale 1ns/1ns
module pmcal_core #(
	parameter int PC_W = pmcal_pkg::PC_W,
	parameter int IMPL_W = pmcal_pkg::IMPL_W,
	parameter logic [13:0] TEMP_VAL = pmcal_pkg::CAL_ERASED,
	parameter logic [13:0] OSC_VAL = pmcal_pkg::CAL_ERASED,
	parameter logic [13:0] SENSE_VAL = pmcal_pkg::CAL_ERASED,
	parameter logic [13:0] HALF_VAL = pmcal_pkg::CAL_ERASED,
	parameter logic [13:0] ADC_VAL = pmcal_pkg::CAL_ERASED,
	parameter logic [13:0] BUF_VAL = pmcal_pkg::CAL_ERASED,
	parameter logic [13:0] GAIN_VAL = pmcal_pkg::CAL_ERASED
) (
	input wire logic ref_clk_in,
	input wire logic reset_in,
	input wire logic fetch_advance_in,
	input wire logic jump_in,
	input wire logic [12:0] jump_target_in,
	input wire logic irq_take_in,
	output logic [12:0] pc_out,
	output logic [13:0] instr_out,
	output logic literal_hit_out,
	output logic [7:0] literal_out,
	input wire logic ptr_rd_in,
	input wire logic ptr_wr_in,
	input wire logic [15:0] indirect_pointer_in,
	output logic ptr_busy_out,
	output logic ptr_valid_out,
	output logic [7:0] ptr_data_out,
	output logic ptr_write_dropped_out,
	input wire logic cal_rd_in,
	input wire logic [13:0] cal_addr_in,
	output logic cal_valid_out,
	output logic cal_hit_out,
	output logic [13:0] cal_data_out,
	input wire logic prog_wr_in,
	input wire logic [11:0] prog_addr_in,
	input wire logic [13:0] prog_data_in
);

	localparam int DEPTH = 1 << IMPL_W;

	// ----------------------------------------------------------------
	// elaboration checks
	// ----------------------------------------------------------------
	if (PC_W != pmcal_pkg::PC_W || IMPL_W > PC_W ||
		IMPL_W != pmcal_pkg::IMPL_W) begin : g_bad_geometry
		$error("pmcal_core: unsupported address widths");
	end

	// folds a logical address onto the implemented words
	function automatic logic [IMPL_W-1:0] pmcal_wrap(
		input logic [PC_W-1:0] a);
		return a[IMPL_W-1:0];
	endfunction : pmcal_wrap

	// ----------------------------------------------------------------
	// program memory array
	// ----------------------------------------------------------------
	logic [13:0] prog_mem [DEPTH];

	// loader port only; the pointer path never writes here
	always_ff @(posedge ref_clk_in) begin
		if (prog_wr_in) begin
			prog_mem[prog_addr_in] <= prog_data_in;
		end
	end

	// ----------------------------------------------------------------
	// program counter and fetch
	// ----------------------------------------------------------------
	logic [PC_W-1:0] pc_d;
	logic [PC_W-1:0] pc_q;
	logic [13:0] instr_d;
	logic [13:0] instr_q;

	always_comb begin
		pc_d = pc_q;
		if (irq_take_in) begin
			pc_d = pmcal_pkg::IRQ_VEC;
		end else if (jump_in) begin
			pc_d = jump_target_in;
		end else if (fetch_advance_in) begin
			pc_d = pc_q + pmcal_pkg::PC_STEP;
		end
		// word lines up with the counter value it belongs to
		instr_d = prog_mem[pmcal_wrap(pc_d)];
	end

	always_ff @(posedge ref_clk_in or posedge reset_in) begin
		if (reset_in) begin
			pc_q <= pmcal_pkg::RESET_VEC;
			instr_q <= pmcal_pkg::WORD_ZERO;
		end else begin
			pc_q <= pc_d;
			instr_q <= instr_d;
		end
	end

	assign pc_out = pc_q;
	assign instr_out = instr_q;
	// table constants come back in the literal field
	assign literal_hit_out = (instr_q[13:pmcal_pkg::OP_LSB] ==
		pmcal_pkg::RETURN_WITH_LITERAL_OP);
	assign literal_out = instr_q[7:0];

	// ----------------------------------------------------------------
	// pointer reads of program space
	// ----------------------------------------------------------------
	pmcal_pkg::pmcal_ptr_state_t ptr_state_d;
	pmcal_pkg::pmcal_ptr_state_t ptr_state_q;
	logic [IMPL_W-1:0] ptr_addr_d;
	logic [IMPL_W-1:0] ptr_addr_q;
	logic [7:0] ptr_data_d;
	logic [7:0] ptr_data_q;
	logic drop_d;
	logic drop_q;
	logic ptr_req;

	assign ptr_req = ptr_rd_in && indirect_pointer_in[pmcal_pkg::PTR_PROG_BIT];

	always_comb begin
		ptr_state_d = ptr_state_q;
		ptr_addr_d = ptr_addr_q;
		ptr_data_d = ptr_data_q;
		// writes toward program space are dropped and flagged
		drop_d = ptr_wr_in &&
			indirect_pointer_in[pmcal_pkg::PTR_PROG_BIT];
		case (ptr_state_q)
			pmcal_pkg::PMCAL_IDLE: begin
				if (ptr_req) begin
					ptr_addr_d = pmcal_wrap(indirect_pointer_in[PC_W-1:0]);
					ptr_state_d = pmcal_pkg::PMCAL_EXTRA;
				end
			end
			pmcal_pkg::PMCAL_EXTRA: begin
				// the extra instruction cycle for a program-space access
				ptr_data_d = prog_mem[ptr_addr_q][7:0];
				ptr_state_d = pmcal_pkg::PMCAL_DONE;
			end
			pmcal_pkg::PMCAL_DONE: begin
				ptr_state_d = pmcal_pkg::PMCAL_IDLE;
			end
			default: begin
				ptr_state_d = pmcal_pkg::PMCAL_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk_in or posedge reset_in) begin
		if (reset_in) begin
			ptr_state_q <= pmcal_pkg::PMCAL_IDLE;
			ptr_addr_q <= '0;
			ptr_data_q <= pmcal_pkg::LIT_ZERO;
			drop_q <= 1'b0;
		end else begin
			ptr_state_q <= ptr_state_d;
			ptr_addr_q <= ptr_addr_d;
			ptr_data_q <= ptr_data_d;
			drop_q <= drop_d;
		end
	end

	assign ptr_busy_out = (ptr_state_q != pmcal_pkg::PMCAL_IDLE);
	assign ptr_valid_out = (ptr_state_q == pmcal_pkg::PMCAL_DONE);
	assign ptr_data_out = ptr_data_q;
	assign ptr_write_dropped_out = drop_q;

	// ----------------------------------------------------------------
	// calibration area access
	// ----------------------------------------------------------------
	pmcal_cal_if cal_bus ();

	pmcal_cal_rom #(
		.TEMP_VAL(TEMP_VAL),
		.OSC_VAL(OSC_VAL),
		.SENSE_VAL(SENSE_VAL),
		.HALF_VAL(HALF_VAL),
		.ADC_VAL(ADC_VAL),
		.BUF_VAL(BUF_VAL),
		.GAIN_VAL(GAIN_VAL)
	) u_cal_rom (
		.cal(cal_bus.rom)
	);

	logic cal_valid_d;
	logic cal_valid_q;
	logic cal_hit_d;
	logic cal_hit_q;
	logic [13:0] cal_data_d;
	logic [13:0] cal_data_q;
	logic [13:0] cal_addr_d;
	logic [13:0] cal_addr_q;

	assign cal_bus.addr = cal_addr_in;

	// no write path exists into this area at all
	always_comb begin
		cal_valid_d = cal_rd_in;
		cal_hit_d = cal_hit_q;
		cal_data_d = cal_data_q;
		cal_addr_d = cal_addr_q;
		if (cal_rd_in) begin
			cal_hit_d = cal_bus.hit;
			cal_data_d = cal_bus.data;
			cal_addr_d = cal_addr_in;
		end
	end

	always_ff @(posedge ref_clk_in or posedge reset_in) begin
		if (reset_in) begin
			cal_valid_q <= 1'b0;
			cal_hit_q <= 1'b0;
			cal_data_q <= pmcal_pkg::WORD_ZERO;
			cal_addr_q <= pmcal_pkg::WORD_ZERO;
		end else begin
			cal_valid_q <= cal_valid_d;
			cal_hit_q <= cal_hit_d;
			cal_data_q <= cal_data_d;
			cal_addr_q <= cal_addr_d;
		end
	end

	assign cal_valid_out = cal_valid_q;
	assign cal_hit_out = cal_hit_q;
	assign cal_data_out = cal_data_q;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (reset_in);

	sequence seq_ptr_req;
		ptr_req && ptr_state_q == pmcal_pkg::PMCAL_IDLE;
	endsequence

	sequence seq_ptr_answer;
		ptr_busy_out && !ptr_valid_out ##1 ptr_valid_out && ptr_busy_out
			##1 !ptr_busy_out;
	endsequence

	chk_reset_start: assert property (
		$fell(reset_in) |-> pc_q == pmcal_pkg::RESET_VEC)
		else $error("counter not zero after reset");

	chk_irq_vector: assert property (
		irq_take_in |=> pc_q == pmcal_pkg::IRQ_VEC)
		else $error("interrupt did not go to word four");

	chk_pc_step: assert property (
		fetch_advance_in && !jump_in && !irq_take_in
		|=> pc_q == $past(pc_q) + pmcal_pkg::PC_STEP)
		else $error("counter did not advance by one");

	chk_fetch_wrap: assert property (
		// the release edge still registers the reset word, so skip it
		!prog_wr_in && !reset_in
		|=> instr_q == prog_mem[pc_q[IMPL_W-1:0]])
		else $error("fetched word not from wrapped address");

	chk_ptr_latency: assert property (
		seq_ptr_req |=> seq_ptr_answer)
		else $error("pointer read timing wrong");

	chk_ptr_low_byte: assert property (
		ptr_valid_out && !$past(prog_wr_in)
		|-> ptr_data_out == prog_mem[ptr_addr_q][7:0])
		else $error("pointer read not low byte");

	chk_ptr_write_drop: assert property (
		ptr_wr_in && indirect_pointer_in[pmcal_pkg::PTR_PROG_BIT]
		|=> ptr_write_dropped_out)
		else $error("pointer write not flagged as dropped");

	chk_cal_zero_fill: assert property (
		cal_rd_in && !cal_bus.hit |=> cal_valid_out && !cal_hit_out &&
			cal_data_out == pmcal_pkg::WORD_ZERO)
		else $error("outside word not zero");

	chk_temp_upper: assert property (
		cal_rd_in && cal_addr_in == pmcal_pkg::TEMPERATURE_READING_WORD
		|=> cal_data_out == {4'h0, TEMP_VAL[9:0]})
		else $error("temperature word wrong");

	chk_adc_scale: assert property (
		cal_rd_in && cal_addr_in == pmcal_pkg::ADC_SCALE_WORD
		|=> cal_data_out == ADC_VAL)
		else $error("adc scale word wrong");

	chk_buf_offset: assert property (
		cal_rd_in && cal_addr_in == pmcal_pkg::TEST_BUFFER_OFFSET_WORD
		|=> cal_data_out == {6'h00, BUF_VAL[7:0]})
		else $error("buffer offset word wrong");

	chk_gain_error: assert property (
		cal_rd_in && cal_addr_in == pmcal_pkg::SENSE_GAIN_ERROR_WORD
		|=> cal_data_out == {6'h00, GAIN_VAL[7:0]})
		else $error("gain error word wrong");

	chk_half_supply: assert property (
		cal_rd_in && cal_addr_in == pmcal_pkg::HALF_SUPPLY_READING_WORD
		|=> cal_data_out == {4'h0, HALF_VAL[9:0]})
		else $error("half supply word wrong");

	chk_cal_read_once: assert property (
		cal_valid_out |-> $past(cal_rd_in) ##1 (cal_valid_out == $past(cal_rd_in)))
		else $error("calibration answer without request");

	chk_literal_flag: assert property (
		literal_hit_out |-> instr_q[13:10] == pmcal_pkg::RETURN_WITH_LITERAL_OP
			&& literal_out == instr_q[7:0])
		else $error("literal flag mismatch");

endmodule : pmcal_core

/* File: src/pmcal_pkg.sv */
package pmcal_pkg;

	// ----------------------------------------------------------------
	// program space geometry
	// ----------------------------------------------------------------
	localparam int PC_W = 13;
	localparam int IMPL_W = 12;
	localparam int WORD_W = 14;
	localparam int LIT_W = 8;
	localparam int PTR_W = 16;
	localparam int PTR_PROG_BIT = 15;
	localparam logic [PC_W-1:0] RESET_VEC = 13'h0000;
	localparam logic [PC_W-1:0] IRQ_VEC = 13'h0004;
	localparam logic [PC_W-1:0] PC_STEP = 13'h0001;
	localparam logic [WORD_W-1:0] WORD_ZERO = 14'h0000;
	localparam logic [LIT_W-1:0] LIT_ZERO = 8'h00;

	// ----------------------------------------------------------------
	// literal-return opcode: top four bits of the word
	// ----------------------------------------------------------------
	localparam int OP_LSB = 10;
	localparam logic [3:0] RETURN_WITH_LITERAL_OP = 4'hD;

	// ----------------------------------------------------------------
	// calibration area
	// ----------------------------------------------------------------
	localparam logic [WORD_W-1:0] CAL_BASE = 14'h2080;
	localparam logic [WORD_W-1:0] CAL_TOP = 14'h208F;
	localparam logic [WORD_W-1:0] TEMPERATURE_READING_WORD = 14'h2084;
	localparam logic [WORD_W-1:0] OSCILLATOR_TRIM_WORD = 14'h2085;
	localparam logic [WORD_W-1:0] SENSE_AMP_OFFSET_WORD = 14'h2086;
	localparam logic [WORD_W-1:0] HALF_SUPPLY_READING_WORD = 14'h2088;
	localparam logic [WORD_W-1:0] ADC_SCALE_WORD = 14'h2089;
	localparam logic [WORD_W-1:0] TEST_BUFFER_OFFSET_WORD = 14'h208A;
	localparam logic [WORD_W-1:0] SENSE_GAIN_ERROR_WORD = 14'h208B;

	// field widths, all fields sit at bit 0
	localparam int TEMP_AT_30C_COUNT_W = 10;
	localparam int OSC_TRIM_BITS_W = 7;
	localparam int SENSE_OFFSET_BITS_W = 7;
	localparam int HALF_SUPPLY_COUNT_W = 10;
	localparam int ADC_SCALE_BITS_W = 14;
	localparam int ADC_FRAC_W = 5;
	localparam int TEST_BUFFER_OFFSET_BITS_W = 8;
	localparam int SENSE_GAIN_ERROR_BITS_W = 8;

	// erased flash value used as plain default for factory words
	localparam logic [WORD_W-1:0] CAL_ERASED = 14'h3FFF;

	typedef enum logic [2:0] {
		PMCAL_IDLE = 3'b001,
		PMCAL_EXTRA = 3'b010,
		PMCAL_DONE = 3'b100
	} pmcal_ptr_state_t;

endpackage : pmcal_pkg

/* File: tb/pmcal_core_model.sv */
`timescale 1ns/1ns
module pmcal_core_model (
	input wire logic clk_in,
	output logic adv_out,
	output logic jump_out,
	output logic irq_out,
	output logic [12:0] target_out,
	output logic ptr_rd_out,
	output logic ptr_wr_out,
	output logic [15:0] pointer_out,
	output logic cal_rd_out,
	output logic [13:0] cal_addr_out,
	output logic prog_wr_out,
	output logic [11:0] prog_addr_out,
	output logic [13:0] prog_data_out,
	input wire logic ptr_valid_in,
	input wire logic ptr_drop_in,
	input wire logic [7:0] ptr_data_in,
	input wire logic cal_valid_in,
	input wire logic cal_hit_in,
	input wire logic [13:0] cal_data_in
);
	logic [6:0] osc_trim_register;
	logic [6:0] sense_offset_register;

	initial begin
		{adv_out, jump_out, irq_out, ptr_rd_out, ptr_wr_out} = 5'h00;
		{cal_rd_out, prog_wr_out} = 2'h0;
		target_out = 13'h0000;
		pointer_out = 16'h0000;
		cal_addr_out = 14'h0000;
		prog_addr_out = 12'h000;
		prog_data_out = 14'h0000;
	end

	// ----------------------------------------------------------------
	// bus tasks
	// ----------------------------------------------------------------
	// released value lines show the inverse so stale values never pass, except the load address, which is held
	task automatic load(input logic [11:0] a, input logic [13:0] d);
		@(posedge clk_in);
		prog_wr_out <= 1'h1;
		prog_addr_out <= a;
		prog_data_out <= d;
		@(posedge clk_in);
		prog_wr_out <= 1'h0;
		prog_data_out <= ~d;
	endtask : load

	task automatic fetch(input logic adv, jmp, irq, input logic [12:0] t);
		@(posedge clk_in);
		{adv_out, jump_out, irq_out} <= {adv, jmp, irq};
		target_out <= t;
		@(posedge clk_in);
		{adv_out, jump_out, irq_out} <= 3'h0;
		target_out <= ~t;
		#1;
	endtask : fetch

	task automatic ptr_read(input logic [15:0] p, output logic [7:0] d,
		output int lat);
		@(posedge clk_in);
		ptr_rd_out <= 1'h1;
		pointer_out <= p;
		@(posedge clk_in);
		ptr_rd_out <= 1'h0;
		pointer_out <= ~p;
		lat = 0;
		d = 8'h00;
		for (int i = 1; i < 6 && lat == 0; i++) begin
			#1;
			if (ptr_valid_in === 1'h1) begin
				lat = i;
				d = ptr_data_in;
			end else
				@(posedge clk_in);
		end
	endtask : ptr_read

	task automatic ptr_write(input logic [15:0] p, output logic drop);
		@(posedge clk_in);
		ptr_wr_out <= 1'h1;
		pointer_out <= p;
		@(posedge clk_in);
		ptr_wr_out <= 1'h0;
		pointer_out <= ~p;
		#1;
		drop = ptr_drop_in;
	endtask : ptr_write

	task automatic cal_read(input logic [13:0] a, output logic [13:0] d,
		output logic h, output logic v);
		@(posedge clk_in);
		cal_rd_out <= 1'h1;
		cal_addr_out <= a;
		@(posedge clk_in);
		cal_rd_out <= 1'h0;
		cal_addr_out <= ~a;
		#1;
		{d, h, v} = {cal_data_in, cal_hit_in, cal_valid_in};
	endtask : cal_read

	// ----------------------------------------------------------------
	// start-up firmware: copy trims into their registers
	// ----------------------------------------------------------------
	task automatic fw_copy();
		logic [13:0] d;
		logic h;
		logic v;
		cal_read(14'h2085, d, h, v);
		osc_trim_register = d[6:0];
		cal_read(14'h2086, d, h, v);
		sense_offset_register = d[6:0];
	endtask : fw_copy
endmodule : pmcal_core_model

/* File: tb/program_memory_map_calibration_test.sv */
`timescale 1ns/1ns
module program_memory_map_calibration_test;
	// upper bits set on purpose so masking shows
	localparam logic [13:0] K_TEMP = 14'h3ABC;
	localparam logic [13:0] K_OSC = 14'h3FD5;
	localparam logic [13:0] K_SENSE = 14'h20A0;
	localparam logic [13:0] K_HALF = 14'h1234;
	localparam logic [13:0] K_ADC = 14'h2C6B;
	localparam logic [13:0] K_BUF = 14'h3F80;
	localparam logic [13:0] K_GAIN = 14'h15A5;
	logic ref_clk_in;
	logic reset_in;
	wire logic adv, jmp, irq, prd, pwr, crd, pgw, busy, pval, pdrop;
	wire logic hit, cval, chit;
	wire logic [12:0] tgt, pc;
	wire logic [13:0] instr, caddr, cdata, pgd;
	wire logic [15:0] ptr;
	wire logic [7:0] lit, pdata;
	wire logic [11:0] pga;
	int miscompares;
	int compares;
	int cycles;
	logic [7:0] d8;
	logic [13:0] d14;
	logic h;
	logic v;
	int lat;

	pmcal_core #(.TEMP_VAL(K_TEMP), .OSC_VAL(K_OSC), .SENSE_VAL(K_SENSE),
		.HALF_VAL(K_HALF), .ADC_VAL(K_ADC), .BUF_VAL(K_BUF),
		.GAIN_VAL(K_GAIN)) DUT (.ref_clk_in(ref_clk_in), .reset_in(reset_in),
		.fetch_advance_in(adv), .jump_in(jmp), .jump_target_in(tgt),
		.irq_take_in(irq), .pc_out(pc), .instr_out(instr),
		.literal_hit_out(hit), .literal_out(lit), .ptr_rd_in(prd),
		.ptr_wr_in(pwr), .indirect_pointer_in(ptr), .ptr_busy_out(busy),
		.ptr_valid_out(pval), .ptr_data_out(pdata),
		.ptr_write_dropped_out(pdrop), .cal_rd_in(crd), .cal_addr_in(caddr),
		.cal_valid_out(cval), .cal_hit_out(chit), .cal_data_out(cdata),
		.prog_wr_in(pgw), .prog_addr_in(pga), .prog_data_in(pgd));

	pmcal_core_model core (.clk_in(ref_clk_in), .adv_out(adv),
		.jump_out(jmp), .irq_out(irq), .target_out(tgt), .ptr_rd_out(prd),
		.ptr_wr_out(pwr), .pointer_out(ptr), .cal_rd_out(crd),
		.cal_addr_out(caddr), .prog_wr_out(pgw), .prog_addr_out(pga),
		.prog_data_out(pgd), .ptr_valid_in(pval), .ptr_drop_in(pdrop),
		.ptr_data_in(pdata), .cal_valid_in(cval), .cal_hit_in(chit),
		.cal_data_in(cdata));

	// ----------------------------------------------------------------
	// reporting
	// ----------------------------------------------------------------
	task automatic check(input string what, input logic [15:0] seen,
		input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic end_of_test();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : end_of_test

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic test_reset();
		// word zero must be known before the first fetch after release
		core.load(12'h000, 14'h3401);
		repeat (4) @(posedge ref_clk_in);
		#1;
		check("pc in reset", pc, 13'h0000);
		check("cal valid in reset", cval, 1'h0);
		reset_in <= 1'h0;
		repeat (3) @(posedge ref_clk_in);
		#1;
		check("pc after reset", pc, 13'h0000);
		$display("test reset done");
	endtask : test_reset

	task automatic test_fetch();
		core.load(12'h000, 14'h3401);
		core.load(12'h004, 14'h2222);
		core.load(12'h005, 14'h0F0F);
		core.load(12'hFFF, 14'h1ABC);
		core.fetch(1'h0, 1'h1, 1'h0, 13'h1FFF);
		check("pc top", pc, 13'h1FFF);
		check("instr top", instr, 14'h1ABC);
		core.fetch(1'h1, 1'h0, 1'h0, 13'h0000);
		check("pc roll", pc, 13'h0000);
		check("instr roll", instr, 14'h3401);
		check("literal hit", hit, 1'h1);
		check("literal", lit, 8'h01);
		core.fetch(1'h0, 1'h1, 1'h0, 13'h1005);
		check("instr alias", instr, 14'h0F0F);
		check("no literal", hit, 1'h0);
		core.fetch(1'h1, 1'h1, 1'h0, 13'h0FFF);
		check("jump over step", pc, 13'h0FFF);
		core.fetch(1'h1, 1'h1, 1'h1, 13'h0100);
		check("irq pc", pc, 13'h0004);
		check("irq instr", instr, 14'h2222);
		$display("test fetch done");
	endtask : test_fetch

	task automatic test_pointer();
		core.ptr_read(16'h9FFF, d8, lat);
		check("ptr data wrap", d8, 8'hBC);
		check("ptr latency", lat, 16'h0002);
		check("ptr busy at answer", busy, 1'h1);
		core.ptr_read(16'h1FFF, d8, lat);
		check("data space read ignored", lat, 16'h0000);
		check("ptr idle", busy, 1'h0);
		core.ptr_write(16'h8005, h);
		check("write dropped", h, 1'h1);
		core.ptr_read(16'h8005, d8, lat);
		check("word kept", d8, 8'h0F);
		$display("test pointer done");
	endtask : test_pointer

	task automatic test_cal();
		logic [13:0] a;
		logic [13:0] e;
		for (int i = 0; i < 18; i++) begin
			a = (i == 17) ? 14'h0084 : 14'(14'h2080 + i);
			case (a)
				14'h2084: e = K_TEMP & 14'h03FF;
				14'h2085: e = K_OSC & 14'h007F;
				14'h2086: e = K_SENSE & 14'h007F;
				14'h2088: e = K_HALF & 14'h03FF;
				14'h2089: e = K_ADC;
				14'h208A: e = K_BUF & 14'h00FF;
				14'h208B: e = K_GAIN & 14'h00FF;
				default: e = 14'h0000;
			endcase
			core.cal_read(a, d14, h, v);
			check("cal data", d14, e);
			check("cal hit", h, a[13:4] == 10'h208);
			check("cal valid", v, 1'h1);
		end
		$display("test calibration done");
	endtask : test_cal

	task automatic test_fw();
		core.fw_copy();
		check("osc trim", core.osc_trim_register, 7'h55);
		check("sense offset", core.sense_offset_register, 7'h20);
		$display("test firmware copy done");
	endtask : test_fw

	// ----------------------------------------------------------------
	// run
	// ----------------------------------------------------------------
	initial begin
		ref_clk_in = 1'h0;
		forever #5 ref_clk_in = ~ref_clk_in;
	end

	// whole run needs under a hundred cycles
	always @(posedge ref_clk_in) begin
		cycles++;
		if (cycles == 3000) begin
			miscompares++;
			$display("timeout");
			end_of_test();
		end
	end

	initial begin
		reset_in = 1'h1;
		test_reset();
		test_fetch();
		test_pointer();
		test_cal();
		test_fw();
		end_of_test();
	end
endmodule : program_memory_map_calibration_test
